// ==== hitd_defs.svh ====
// Field positions and constants of the isochronous transfer descriptor.
// Assumes word 0 = DW1:DW0, word 1 = DW3:DW2, mask = DW4[7:0].
`ifndef HITD_DEFS_SVH
`define HITD_DEFS_SVH
`define HITD_W0_RUN     0
`define HITD_W0_LEN     17:3
`define HITD_W0_LIMIT   28:18
`define HITD_W0_MULT    30:29
`define HITD_W0_EP_LO   31
`define HITD_W0_EP_HI   34:32
`define HITD_W0_ADDR    41:35
`define HITD_W0_TOKEN   43:42
`define HITD_W0_CLASS   45:44
`define HITD_W0_SPLIT   46
`define HITD_W1_FRAME   7:3
`define HITD_W1_PTR     23:8
`define HITD_W1_LIVE    63
`define HITD_TOK_OUT    2'h0
`define HITD_TOK_IN     2'h1
`define HITD_CLASS_ISO  2'h1
`define HITD_MAX_PKT    11'h400
`define HITD_RES_XERR   0
`define HITD_RES_BABBLE 1
`define HITD_RES_UNDER  2
`endif

// ==== hitd_pkg.sv ====
// Types shared by the descriptor executor.
// Assumes hitd_defs.svh is available on the include path.
package hitd_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ARMED = 3'h1,
        ST_ISSUE = 3'h3,
        ST_WAIT  = 3'h2,
        ST_WB    = 3'h6
    } hitd_state_t;
    typedef logic [2:0] hitd_result_t;
endpackage : hitd_pkg

// ==== hitd_decode.sv ====
// Field decoder for a captured descriptor.
// Assumes both words are held stable in registers by the caller.
`timescale 1ns/100ps
`include "hitd_defs.svh"
module hitd_decode import hitd_pkg::*; (
    // Captured descriptor
    input  wire logic [63:0] w0,
    input  wire logic [63:0] w1,
    // Decoded fields
    output logic [3:0]       ep_num,
    output logic [10:0]      limit_eff,
    output logic [2:0]       mult_eff,
    output logic             is_in,
    output logic             bad_desc
);
    assign ep_num    = {w0[`HITD_W0_EP_HI], w0[`HITD_W0_EP_LO]};
    // Oversized limits are clipped rather than trusted
    assign limit_eff = (w0[`HITD_W0_LIMIT] > `HITD_MAX_PKT) ? `HITD_MAX_PKT
                     : w0[`HITD_W0_LIMIT];
    // A zero multiplier still moves one packet
    assign mult_eff  = (w0[`HITD_W0_MULT] == 2'h0) ? 3'h1
                     : {1'b0, w0[`HITD_W0_MULT]};
    assign is_in     = (w0[`HITD_W0_TOKEN] == `HITD_TOK_IN);
    assign bad_desc  = (w0[`HITD_W0_CLASS] != `HITD_CLASS_ISO)
                     || (w0[`HITD_W0_TOKEN] != `HITD_TOK_IN
                         && w0[`HITD_W0_TOKEN] != `HITD_TOK_OUT);
endmodule : hitd_decode

// ==== hitd_accum.sv ====
// Byte-done counter and payload address generator.
// Assumes clr and add are never asserted together.
`timescale 1ns/100ps
`include "hitd_defs.svh"
module hitd_accum import hitd_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        clr,
    input  wire logic        add,
    input  wire logic [10:0] add_bytes,
    input  wire logic [14:0] total,
    input  wire logic [15:0] base_ptr,
    // State
    output logic [14:0]      done_q,
    output logic [14:0]      remain,
    output logic [15:0]      ram_addr,
    output logic [2:0]       ram_byte
);
    logic [14:0] done_d;
    assign remain = total - done_q;
    // Never count past the buffer depth, even on a babbling IN
    assign done_d = ({4'h0, add_bytes} >= remain) ? total
                  : done_q + {4'h0, add_bytes};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 15'h0000;
        end else if (clr) begin
            done_q <= 15'h0000;
        end else if (add) begin
            done_q <= done_d;
        end
    end
    assign ram_addr = base_ptr + {4'h0, done_q[14:3]};
    assign ram_byte = done_q[2:0];
endmodule : hitd_accum

// ==== hitd_core.sv ====
// Executor for one high-speed isochronous transfer descriptor.
// Assumes the link logic runs on clk and answers each request once.
`timescale 1ns/100ps
`include "hitd_defs.svh"
// Functional notes
// - Live bit at word bit 63 counts as run_enable.
// - One stop_flag per descriptor; setting it clears run_enable.
// - Endpoint stall from the device sets the stop_flag.
// - Overrun flag is never reported for isochronous.
// - bytes_done_count holds bytes actually moved, 15 bits.
// - Partial totals may appear during multi-packet execution.
// - payload_ram_pointer is a word address; data fetched from there.
// - Frame bits 7:3 select the execution frame; bits 2:0 ignored.
// - hub_relay set means split transaction, else direct.
// - Token 00 issues OUT, 01 issues IN.
// - Seven-bit device address selects the USB function.
// - endpoint_number is concatenated from two split fields.
// - packets_per_microframe bounds packets per microframe.
// - packet_size_limit caps each packet, at most 1024.
// - transfer_length bounds total bytes moved.
// - run_enable cleared on completion or fatal error.
// - Only microframes with mask bit set transfer; each cleared after.
// - Per microframe result: error, babble on IN, underrun on OUT.
module hitd_core import hitd_pkg::*; (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Descriptor load
    input  wire logic        desc_load,
    input  wire logic [63:0] desc_w0,
    input  wire logic [63:0] desc_w1,
    input  wire logic [7:0]  desc_mask,
    output logic             desc_busy,
    output logic             desc_skip,
    // Bus timing
    input  wire logic        sof,
    input  wire logic [4:0]  bus_frame,
    input  wire logic [2:0]  bus_uframe,
    // Transaction request
    output logic             txn_req,
    input  wire logic        txn_ack,
    output logic             txn_in,
    output logic             txn_split,
    output logic [6:0]       txn_addr,
    output logic [3:0]       txn_ep,
    output logic [10:0]      txn_len,
    output logic [15:0]      txn_ram_addr,
    output logic [2:0]       txn_ram_byte,
    // Transaction answer
    input  wire logic        txn_done,
    input  wire logic [10:0] txn_bytes,
    input  wire logic        txn_stall,
    input  wire logic        txn_xerr,
    input  wire logic        txn_babble,
    input  wire logic        txn_underrun,
    input  wire logic        txn_fatal,
    // Write-back
    output logic             wb_valid,
    output logic             wb_active,
    output logic             wb_halt,
    output logic             wb_overrun,
    output logic [14:0]      wb_bytes,
    output logic [7:0]       wb_mask,
    output logic [23:0]      wb_result,
    // Live view
    output logic [14:0]      bytes_done,
    output logic             run_enable
);
    hitd_state_t  st_q;
    logic [63:0]  w0_q;
    logic [63:0]  w1_q;
    logic [7:0]   mask_q;
    logic [23:0]  res_q;
    hitd_result_t ures_q;
    logic [2:0]   uf_q;
    logic [2:0]   pkt_left_q;
    logic [10:0]  len_q;
    logic         halt_q;
    logic         run_q;
    logic [3:0]   ep_num;
    logic [10:0]  limit_eff;
    logic [2:0]   mult_eff;
    logic         is_in;
    logic         bad_desc;
    logic [14:0]  remain;
    logic [15:0]  ram_addr;
    logic [2:0]   ram_byte;
    logic         load_live;
    logic         frame_hit;
    logic         uf_start;
    logic         resp;
    logic         stop_now;
    logic         uf_close;
    logic         last_uf;
    logic [10:0]  pkt_len;
    hitd_result_t ures_d;

    hitd_decode u_decode (
        .w0        (w0_q),
        .w1        (w1_q),
        .ep_num    (ep_num),
        .limit_eff (limit_eff),
        .mult_eff  (mult_eff),
        .is_in     (is_in),
        .bad_desc  (bad_desc)
    );

    hitd_accum u_accum (
        .clk       (clk),
        .arst_n    (arst_n),
        .clr       (st_q == ST_IDLE && desc_load && load_live),
        .add       (resp),
        .add_bytes (txn_bytes),
        .total     (w0_q[`HITD_W0_LEN]),
        .base_ptr  (w1_q[`HITD_W1_PTR]),
        .done_q    (bytes_done),
        .remain    (remain),
        .ram_addr  (ram_addr),
        .ram_byte  (ram_byte)
    );

    assign load_live = desc_w0[`HITD_W0_RUN] | desc_w1[`HITD_W1_LIVE];
    assign frame_hit = (bus_frame == w1_q[`HITD_W1_FRAME]);
    assign uf_start  = sof && frame_hit && mask_q[bus_uframe];
    assign resp      = (st_q == ST_WAIT) && txn_done;
    assign stop_now  = txn_stall || txn_fatal;
    // Short packet or exhausted buffer also ends the microframe
    assign uf_close  = resp && !stop_now
                     && (pkt_left_q == 3'h1 || txn_bytes < len_q
                         || {4'h0, txn_bytes} >= remain);
    assign last_uf   = ((mask_q & ~(8'h01 << uf_q)) == 8'h00)
                     || {4'h0, txn_bytes} >= remain;
    assign pkt_len   = ({4'h0, limit_eff} > remain) ? remain[10:0]
                     : limit_eff;

    always_comb begin
        ures_d = ures_q;
        ures_d[`HITD_RES_XERR]   = ures_q[`HITD_RES_XERR] | txn_xerr;
        ures_d[`HITD_RES_BABBLE] = ures_q[`HITD_RES_BABBLE]
                                 | (txn_babble & is_in);
        ures_d[`HITD_RES_UNDER]  = ures_q[`HITD_RES_UNDER]
                                 | (txn_underrun & ~is_in);
    end

    // Sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (desc_load && load_live) begin
                        st_q <= ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (bad_desc || mask_q == 8'h00 || remain == 15'h0000) begin
                        st_q <= ST_WB;
                    end else if (uf_start) begin
                        st_q <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (txn_ack) begin
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (resp && stop_now) begin
                        st_q <= ST_WB;
                    end else if (uf_close) begin
                        st_q <= last_uf ? ST_WB : ST_ARMED;
                    end else if (resp) begin
                        st_q <= ST_ISSUE;
                    end
                end
                ST_WB: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Descriptor capture; untouched when not live
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w0_q <= 64'h0;
            w1_q <= 64'h0;
        end else if (st_q == ST_IDLE && desc_load && load_live) begin
            w0_q <= desc_w0;
            w1_q <= desc_w1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            desc_skip <= 1'b0;
        end else begin
            desc_skip <= (st_q == ST_IDLE) && desc_load && !load_live;
        end
    end

    // Packet bookkeeping within a microframe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uf_q       <= 3'h0;
            pkt_left_q <= 3'h0;
            len_q      <= 11'h000;
            ures_q     <= 3'h0;
        end else if (st_q == ST_ARMED && uf_start) begin
            uf_q       <= bus_uframe;
            pkt_left_q <= mult_eff;
            len_q      <= pkt_len;
            ures_q     <= 3'h0;
        end else if (resp) begin
            pkt_left_q <= pkt_left_q - 3'h1;
            ures_q     <= ures_d;
            if ({4'h0, limit_eff} > remain - {4'h0, txn_bytes}) begin
                len_q <= remain[10:0] - txn_bytes;
            end else begin
                len_q <= limit_eff;
            end
        end
    end

    // Per-microframe mask and result slices
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_uf
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    mask_q[gi]           <= 1'b0;
                    res_q[gi*3 +: 3]     <= 3'h0;
                end else if (st_q == ST_IDLE && desc_load && load_live) begin
                    mask_q[gi]           <= desc_mask[gi];
                    res_q[gi*3 +: 3]     <= 3'h0;
                end else if ((uf_close || (resp && stop_now)) && uf_q == gi) begin
                    mask_q[gi]           <= 1'b0;
                    res_q[gi*3 +: 3]     <= ures_d;
                end
            end
        end
    endgenerate

    // Activity and stop flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q  <= 1'b0;
            halt_q <= 1'b0;
        end else if (st_q == ST_IDLE && desc_load && load_live) begin
            run_q  <= 1'b1;
            halt_q <= 1'b0;
        end else if (resp && txn_stall) begin
            run_q  <= 1'b0;
            halt_q <= 1'b1;
        end else if (st_q == ST_WB) begin
            run_q  <= 1'b0;
        end
    end

    // Write-back image
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_valid   <= 1'b0;
            wb_active  <= 1'b0;
            wb_halt    <= 1'b0;
            wb_overrun <= 1'b0;
            wb_bytes   <= 15'h0000;
            wb_mask    <= 8'h00;
            wb_result  <= 24'h000000;
        end else begin
            wb_valid   <= (st_q == ST_WB);
            wb_overrun <= 1'b0;
            if (st_q == ST_WB) begin
                wb_active <= 1'b0;
                wb_halt   <= halt_q;
                wb_bytes  <= bytes_done;
                wb_mask   <= mask_q;
                wb_result <= res_q;
            end
        end
    end

    assign desc_busy    = (st_q != ST_IDLE);
    assign txn_req      = (st_q == ST_ISSUE);
    assign txn_in       = is_in;
    assign txn_split    = w0_q[`HITD_W0_SPLIT];
    assign txn_addr     = w0_q[`HITD_W0_ADDR];
    assign txn_ep       = ep_num;
    assign txn_len      = len_q;
    assign txn_ram_addr = ram_addr;
    assign txn_ram_byte = ram_byte;
    assign run_enable   = run_q;

    skip_untouched_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_IDLE && desc_load && !load_live |=> desc_skip && st_q == ST_IDLE)
        else $error("inactive descriptor was not skipped");
    live_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_IDLE && desc_load && desc_w1[`HITD_W1_LIVE] |=> run_enable)
        else $error("live bit did not activate descriptor");
    stall_halts_a: assert property (@(posedge clk) disable iff (!arst_n)
        resp && txn_stall |=> st_q == ST_WB ##1 wb_valid && wb_halt && !wb_active)
        else $error("stall did not halt descriptor");
    halt_clears_run_a: assert property (@(posedge clk) disable iff (!arst_n)
        halt_q |-> !run_enable)
        else $error("stop flag set with run enable high");
    no_overrun_a: assert property (@(posedge clk) disable iff (!arst_n)
        wb_valid |-> !wb_overrun)
        else $error("overrun reported for isochronous");
    token_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
        txn_req |-> txn_in == (w0_q[`HITD_W0_TOKEN] == `HITD_TOK_IN)
            && (w0_q[`HITD_W0_TOKEN] == `HITD_TOK_IN || w0_q[`HITD_W0_TOKEN] == `HITD_TOK_OUT))
        else $error("token direction mismatch");
    frame_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_ISSUE && $past(st_q) == ST_ARMED
        |-> $past(bus_frame) == w1_q[`HITD_W1_FRAME] && $past(sof))
        else $error("issued outside selected frame");
    len_cap_a: assert property (@(posedge clk) disable iff (!arst_n)
        txn_req |-> txn_len <= `HITD_MAX_PKT && txn_len <= w0_q[`HITD_W0_LIMIT])
        else $error("packet longer than limit");
    bytes_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
        bytes_done <= w0_q[`HITD_W0_LEN])
        else $error("bytes done beyond transfer length");
    mask_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        uf_close |=> !mask_q[$past(uf_q)])
        else $error("microframe mask bit not cleared");
    ram_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
        txn_req |-> txn_ram_addr == w1_q[`HITD_W1_PTR] + {4'h0, bytes_done[14:3]})
        else $error("payload address wrong");
    wb_inactive_a: assert property (@(posedge clk) disable iff (!arst_n)
        st_q == ST_WB |=> wb_valid && !wb_active && !run_enable)
        else $error("run enable not cleared at completion");
    fatal_ends_a: assert property (@(posedge clk) disable iff (!arst_n)
        resp && txn_fatal && !txn_stall |=> st_q == ST_WB ##1 wb_valid && !wb_halt)
        else $error("fatal error did not end descriptor");
endmodule : hitd_core

// ==== hitd_link_model.sv ====
// Behavioural far-side link and isochronous endpoint for hitd_core.
// Assumes requests come from hitd_core on clk; answers change 0.5 ns after an edge.
// Half a nanosecond keeps answers clear of the bench's 1 ns sample point.
`timescale 1ns/100ps
module hitd_link_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Request from the executor
    input  wire logic        txn_req,
    input  wire logic        txn_in,
    input  wire logic [10:0] txn_len,
    // Scenario control: bit0 stall, bit1 xerr, bit2 babble or underrun, bit3 fatal
    input  wire logic [3:0]  fault,
    input  wire logic [10:0] short_by,
    input  wire logic [3:0]  lat,
    // Answer
    output logic             txn_ack,
    output logic             txn_done,
    output logic [10:0]      txn_bytes,
    output logic             txn_stall,
    output logic             txn_xerr,
    output logic             txn_babble,
    output logic             txn_underrun,
    output logic             txn_fatal
);
    logic [10:0] seen_len;
    logic        seen_in;

    initial begin
        txn_ack = 1'b0;
        txn_done = 1'b0;
        {txn_bytes, txn_stall, txn_xerr, txn_babble, txn_underrun, txn_fatal} = 16'h5555;
        forever begin
            @(posedge clk);
            if (arst_n === 1'b1 && txn_req === 1'b1) begin
                seen_len = txn_len;
                seen_in = txn_in;
                repeat (lat) @(posedge clk);
                #0.5 txn_ack = 1'b1;
                @(posedge clk);
                #0.5 txn_ack = 1'b0;
                repeat (lat) @(posedge clk);
                if (lat != 4'h0) #0.5;
                txn_done = 1'b1;
                txn_bytes = seen_len - short_by;
                txn_stall = fault[0];
                txn_xerr = fault[1];
                txn_babble = fault[2] & seen_in;
                txn_underrun = fault[2] & ~seen_in;
                txn_fatal = fault[3];
                @(posedge clk);
                #0.5 txn_done = 1'b0;
                // Released answer lines must not keep a believable value
                {txn_bytes, txn_stall, txn_xerr, txn_babble, txn_underrun, txn_fatal} =
                    ~{txn_bytes, txn_stall, txn_xerr, txn_babble, txn_underrun, txn_fatal};
            end
        end
    end
endmodule : hitd_link_model

// ==== hitd_core_bench.sv ====
// Self-checking bench for hitd_core with a behavioural link model.
// Assumes hitd_defs.svh and hitd_pkg are compiled first.
`timescale 1ns/100ps
`include "hitd_defs.svh"
`define HITD_CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin num_errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end
module hitd_core_bench;
    import hitd_pkg::*;
    logic        clk, arst_n, desc_load, sof, txn_req, txn_ack, txn_in, txn_split;
    logic        desc_busy, desc_skip, txn_done, txn_stall, txn_xerr, txn_babble;
    logic        txn_underrun, txn_fatal, wb_valid, wb_active, wb_halt, wb_overrun;
    logic        run_enable;
    logic [63:0] desc_w0, desc_w1;
    logic [7:0]  desc_mask, wb_mask;
    logic [4:0]  bus_frame;
    logic [2:0]  bus_uframe, txn_ram_byte;
    logic [6:0]  txn_addr;
    logic [3:0]  txn_ep, fault, lat;
    logic [10:0] txn_len, txn_bytes, short_by;
    logic [15:0] txn_ram_addr;
    logic [14:0] wb_bytes, bytes_done;
    logic [23:0] wb_result;
    int          num_errors = 0;
    int          n_checks = 0;

    hitd_core dut (.clk, .arst_n, .desc_load, .desc_w0, .desc_w1, .desc_mask, .desc_busy,
        .desc_skip, .sof, .bus_frame, .bus_uframe, .txn_req, .txn_ack, .txn_in, .txn_split,
        .txn_addr, .txn_ep, .txn_len, .txn_ram_addr, .txn_ram_byte, .txn_done, .txn_bytes,
        .txn_stall, .txn_xerr, .txn_babble, .txn_underrun, .txn_fatal, .wb_valid, .wb_active,
        .wb_halt, .wb_overrun, .wb_bytes, .wb_mask, .wb_result, .bytes_done, .run_enable);
    hitd_link_model link (.clk, .arst_n, .txn_req, .txn_in, .txn_len, .fault, .short_by,
        .lat, .txn_ack, .txn_done, .txn_bytes, .txn_stall, .txn_xerr, .txn_babble,
        .txn_underrun, .txn_fatal);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    function automatic logic pick(input int k);
        case (k)
            0: return txn_req;
            1: return txn_done;
            2: return desc_skip;
            default: return wb_valid;
        endcase
    endfunction : pick

    // Bounded wait; a hang counts as a mismatch
    task automatic wait_for(input int k);
        int i;
        for (i = 0; i < 40 && pick(k) !== 1'b1; i++) tick();
        if (pick(k) !== 1'b1) begin
            num_errors++;
            end_of_test();
        end
    endtask : wait_for

    // Reserved ranges stay zero, class given by caller
    function automatic logic [63:0] mk_w0(input logic run, input logic [14:0] len,
        input logic [10:0] lim, input logic [1:0] mult, input logic [3:0] ep,
        input logic [6:0] addr, input logic [1:0] tok, input logic [1:0] cls,
        input logic split);
        logic [63:0] w;
        w = '0;
        w[`HITD_W0_RUN] = run;
        w[`HITD_W0_LEN] = len;
        w[`HITD_W0_LIMIT] = lim;
        w[`HITD_W0_MULT] = mult;
        w[`HITD_W0_EP_LO] = ep[0];
        w[`HITD_W0_EP_HI] = ep[3:1];
        w[`HITD_W0_ADDR] = addr;
        w[`HITD_W0_TOKEN] = tok;
        w[`HITD_W0_CLASS] = cls;
        w[`HITD_W0_SPLIT] = split;
        return w;
    endfunction : mk_w0

    function automatic logic [63:0] mk_w1(input logic live, input logic [4:0] frame,
        input logic [2:0] low, input logic [15:0] ptr);
        logic [63:0] w;
        w = '0;
        w[`HITD_W1_FRAME] = frame;
        w[2:0] = low;
        w[`HITD_W1_PTR] = ptr;
        w[`HITD_W1_LIVE] = live;
        return w;
    endfunction : mk_w1

    task automatic load(input logic [63:0] w0, input logic [63:0] w1, input logic [7:0] m);
        desc_w0 = w0;
        desc_w1 = w1;
        desc_mask = m;
        desc_load = 1'b1;
        tick();
        desc_load = 1'b0;
    endtask : load

    task automatic sof_at(input logic [4:0] f, input logic [2:0] u);
        sof = 1'b1;
        bus_frame = f;
        bus_uframe = u;
        tick();
        sof = 1'b0;
    endtask : sof_at

    task automatic s_skip();
        load(mk_w0(1'b0, 15'h0010, 11'h010, 2'h1, 4'h1, 7'h01, 2'h0, 2'h1, 1'b0),
             mk_w1(1'b0, 5'h00, 3'h0, 16'h0000), 8'hFF);
        `HITD_CHK(desc_busy, 1'b0);
        wait_for(2);
        `HITD_CHK(run_enable, 1'b0);
        `HITD_CHK(wb_valid, 1'b0);
    endtask : s_skip

    task automatic s_bad_class();
        load(mk_w0(1'b1, 15'h0010, 11'h010, 2'h1, 4'h1, 7'h01, 2'h0, 2'h2, 1'b0),
             mk_w1(1'b0, 5'h00, 3'h0, 16'h0000), 8'hFF);
        wait_for(3);
        `HITD_CHK(wb_active, 1'b0);
        `HITD_CHK(wb_bytes, 15'h0000);
        tick();
        `HITD_CHK(run_enable, 1'b0);
    endtask : s_bad_class

    task automatic s_out();
        load(mk_w0(1'b0, 15'h012C, 11'h0C8, 2'h1, 4'hB, 7'h5A, `HITD_TOK_OUT, 2'h1, 1'b1),
             mk_w1(1'b1, 5'h09, 3'h5, 16'h1234), 8'h05);
        `HITD_CHK(run_enable, 1'b1);
        sof_at(5'h08, 3'h0);
        tick();
        `HITD_CHK(txn_req, 1'b0);
        sof_at(5'h09, 3'h1);
        tick();
        `HITD_CHK(txn_req, 1'b0);
        fault = 4'h2;
        sof_at(5'h09, 3'h0);
        wait_for(0);
        `HITD_CHK(txn_in, 1'b0);
        `HITD_CHK(txn_split, 1'b1);
        `HITD_CHK(txn_addr, 7'h5A);
        `HITD_CHK(txn_ep, 4'hB);
        `HITD_CHK(txn_len, 11'h0C8);
        `HITD_CHK(txn_ram_addr, 16'h1234);
        wait_for(1);
        tick();
        `HITD_CHK(bytes_done, 15'h00C8);
        fault = 4'h4;
        sof_at(5'h09, 3'h2);
        wait_for(0);
        `HITD_CHK(txn_len, 11'h064);
        `HITD_CHK(txn_ram_addr, 16'h124D);
        `HITD_CHK(txn_ram_byte, 3'h0);
        wait_for(3);
        `HITD_CHK(wb_bytes, 15'h012C);
        `HITD_CHK(wb_active, 1'b0);
        `HITD_CHK(wb_overrun, 1'b0);
        `HITD_CHK(wb_mask, 8'h00);
        `HITD_CHK(wb_result, 24'h000101);
    endtask : s_out

    task automatic s_in_mult();
        fault = 4'h0;
        lat = 4'h3;
        load(mk_w0(1'b1, 15'h0096, 11'h064, 2'h2, 4'h2, 7'h11, `HITD_TOK_IN, 2'h1, 1'b0),
             mk_w1(1'b0, 5'h1F, 3'h0, 16'h0040), 8'h88);
        sof_at(5'h1F, 3'h3);
        wait_for(0);
        `HITD_CHK(txn_in, 1'b1);
        `HITD_CHK(txn_split, 1'b0);
        wait_for(1);
        tick();
        `HITD_CHK(bytes_done, 15'h0064);
        fault = 4'h4;
        wait_for(0);
        `HITD_CHK(txn_len, 11'h032);
        `HITD_CHK(txn_ram_addr, 16'h004C);
        `HITD_CHK(txn_ram_byte, 3'h4);
        wait_for(3);
        `HITD_CHK(wb_bytes, 15'h0096);
        `HITD_CHK(wb_mask, 8'h80);
        `HITD_CHK(wb_result, 24'h000400);
        `HITD_CHK(wb_halt, 1'b0);
    endtask : s_in_mult

    task automatic s_stall();
        fault = 4'h1;
        lat = 4'h0;
        load(mk_w0(1'b1, 15'h0040, 11'h040, 2'h1, 4'h3, 7'h22, `HITD_TOK_OUT, 2'h1, 1'b0),
             mk_w1(1'b0, 5'h00, 3'h0, 16'h0100), 8'h03);
        sof_at(5'h00, 3'h0);
        wait_for(3);
        `HITD_CHK(wb_halt, 1'b1);
        `HITD_CHK(wb_active, 1'b0);
        `HITD_CHK(wb_mask, 8'h02);
        tick();
        `HITD_CHK(run_enable, 1'b0);
    endtask : s_stall

    // Zero multiplier, oversized limit, fatal link error
    task automatic s_fatal();
        fault = 4'h8;
        lat = 4'h0;
        load(mk_w0(1'b1, 15'h1000, 11'h7FF, 2'h0, 4'h4, 7'h33, `HITD_TOK_IN, 2'h1, 1'b0),
             mk_w1(1'b0, 5'h00, 3'h0, 16'h0200), 8'h01);
        sof_at(5'h00, 3'h0);
        wait_for(0);
        `HITD_CHK(txn_len, 11'h400);
        wait_for(3);
        `HITD_CHK(wb_halt, 1'b0);
        `HITD_CHK(wb_bytes, 15'h0400);
        `HITD_CHK(wb_mask, 8'h00);
        `HITD_CHK(wb_result, 24'h000000);
        tick();
        `HITD_CHK(run_enable, 1'b0);
    endtask : s_fatal

    initial begin
        {arst_n, desc_load, sof, desc_mask, bus_frame, bus_uframe} = '0;
        {desc_w0, desc_w1} = '0;
        fault = 4'h0;
        short_by = 11'h000;
        lat = 4'h1;
        repeat (4) @(posedge clk);
        #1 arst_n = 1'b1;
        tick();
        s_skip();
        s_bad_class();
        s_out();
        s_in_mult();
        s_stall();
        s_fatal();
        end_of_test();
    end
endmodule : hitd_core_bench
